// ===== verilog/pid_autotune_pkg.sv
package pid_autotune_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ          = 20_000_000;
	localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
	localparam int unsigned SHIFT_HOLD_MS   = 2000;
	localparam int unsigned SHIFT_HOLD_CYC  = SHIFT_HOLD_MS * CYC_PER_MS;
	localparam int unsigned PWR_FAIL_MS     = 20;
	// Longer than the limit: one cycle past the limit counts as a failure.
	localparam int unsigned PWR_FAIL_CYC    = PWR_FAIL_MS * CYC_PER_MS + 1;
	localparam int unsigned RUN_SETTLE_MS   = 200;
	localparam int unsigned SAMPLE_MS       = 100;
	localparam int unsigned RUN_SETTLE_CYC  = (RUN_SETTLE_MS + SAMPLE_MS) * CYC_PER_MS;
	localparam int unsigned TUNE_LIMIT_S    = 7200;
	localparam int unsigned SEC_CYC         = CLK_HZ;
	localparam int unsigned FLASH_MS        = 500;
	localparam int unsigned FLASH_CYC       = FLASH_MS * CYC_PER_MS;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] A_CTRL   = 8'h00;
	localparam logic [7:0] A_OUTLIM = 8'h04;
	localparam logic [7:0] A_ERRPT  = 8'h08;
	localparam logic [7:0] A_MEAS   = 8'h0C;
	localparam logic [7:0] A_TARGET = 8'h10;
	localparam logic [7:0] A_PVADJ  = 8'h14;
	localparam logic [7:0] A_AREA   = 8'h18;
	localparam logic [7:0] A_TUNOUT = 8'h1C;
	localparam logic [7:0] A_LIMIT  = 8'h20;
	localparam logic [7:0] A_PID_P  = 8'h24;
	localparam logic [7:0] A_PID_I  = 8'h28;
	localparam logic [7:0] A_PID_D  = 8'h2C;
	localparam logic [7:0] A_STATUS = 8'h30;

	localparam int CTRL_RUN   = 0;
	localparam int CTRL_AUTO  = 1;
	localparam int CTRL_LOCAL = 2;
	localparam int CTRL_PID   = 3;
	localparam int CTRL_VALVE = 4;

	localparam logic [4:0]  CTRL_RST   = 5'h0F;
	localparam logic [15:0] LIM_HI_RST = 16'h03E8;
	localparam logic [15:0] LIM_LO_RST = 16'h0000;
	localparam logic [15:0] ERR_HI_RST = 16'hFFFF;
	localparam logic [15:0] ERR_LO_RST = 16'h0000;
	localparam logic [15:0] PID_P_RST  = 16'h001E;
	localparam logic [15:0] PID_I_RST  = 16'h00F0;
	localparam logic [15:0] PID_D_RST  = 16'h003C;
	localparam logic [15:0] LIMIT_RST  = 16'hFFFF;

	// Output limits are in steps of 0.1 %.
	localparam logic [15:0] OUT_HI_MIN = 16'h0001;
	localparam logic [15:0] OUT_LO_MAX = 16'h03E7;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_TUNE = 2'b10
	} tune_state_e;

	typedef enum logic [3:0] {
		C_NONE    = 4'h0,
		C_DONE    = 4'h1,
		C_STOP    = 4'h2,
		C_SEL     = 4'h3,
		C_MANUAL  = 4'h4,
		C_REMOTE  = 4'h5,
		C_TARGET  = 4'h6,
		C_PVADJ   = 4'h7,
		C_AREA    = 4'h8,
		C_INPUT   = 4'h9,
		C_TIMEOUT = 4'hA,
		C_POWER   = 4'hB,
		C_FAIL    = 4'hC
	} cause_e;

endpackage

// ===== verilog/pin_sync3.sv
`timescale 1ns/1ps
module pin_sync3 #(
	parameter int         W    = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] pin,
	output logic      [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} sync_s;

	sync_s s;
	sync_s next_s;

	if (W < 1) begin : g_bad
		$error("pin_sync3 width must be at least one");
	end

	// A bit only moves once the second and third stages agree.
	always_comb begin
		next_s    = s;
		next_s.s1 = pin;
		next_s.s2 = s.s1;
		next_s.s3 = s.s2;
		next_s.q  = (s.q & ~(s.s2 ~^ s.s3)) | (s.s3 & (s.s2 ~^ s.s3));
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= {INIT, INIT, INIT, INIT};
		end else begin
			s <= next_s;
		end
	end

	assign q = s.q;
endmodule

// ===== verilog/hold_timer.sv
`timescale 1ns/1ps
module hold_timer #(
	parameter int unsigned CYCLES = 1
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic level,
	output logic      fire,
	output logic      held
);
	typedef struct packed {
		logic [31:0] cnt;
		logic        held;
		logic        fire;
	} hold_s;

	hold_s s;
	hold_s next_s;

	if (CYCLES < 1) begin : g_bad
		$error("hold_timer needs at least one cycle");
	end

	// The count restarts whenever the level drops, so bounces never add up.
	always_comb begin
		next_s      = s;
		next_s.fire = 1'b0;
		if (!level) begin
			next_s.cnt  = '0;
			next_s.held = 1'b0;
		end else if (!s.held) begin
			if (s.cnt == CYCLES - 1) begin
				next_s.held = 1'b1;
				next_s.fire = 1'b1;
			end else begin
				next_s.cnt = s.cnt + 32'h1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign fire = s.fire;
	assign held = s.held;
endmodule

// ===== verilog/pid_autotune_sequencer.sv
// Overview of operation
// - Start only in run, PID, auto, local.
// - Start needs limiter high>=0.1%, low<=99.9%.
// - Start needs valid value within error points.
// - Up key on selector starts; lamp flashes.
// - Completion loads new values, lamp off.
// - Cancel leaves tuning, keeps previous values.
// - Change to stop cancels tuning.
// - Selector set off with down cancels.
// - Change to manual cancels tuning.
// - Change to remote cancels tuning.
// - Target value change cancels tuning.
// - Bias, filter or ratio change cancels.
// - Control area change cancels tuning.
// - Invalid or out-of-range value cancels tuning.
// - Tuning longer than two hours cancels.
// - Supply loss over 20 ms cancels.
// - Instrument failure state cancels tuning.
// - Start allowed any time after power-up.
// - Zero limiter removes integral or derivative term.
// - Tuning on/off outputs apply only while tuning.
// - Valve mode needs feedback input connected.
// - Shift held 2 s opens selector screen.
// - Run contact takes effect after 300 ms.
`timescale 1ns/1ps
module pid_autotune_sequencer
	import pid_autotune_pkg::*;
#(
	parameter int unsigned SHIFT_HOLD_CYCLES = SHIFT_HOLD_CYC,
	parameter int unsigned PWR_FAIL_CYCLES   = PWR_FAIL_CYC,
	parameter int unsigned RUN_SETTLE_CYCLES = RUN_SETTLE_CYC,
	parameter int unsigned SEC_CYCLES        = SEC_CYC,
	parameter int unsigned TUNE_LIMIT_SEC    = TUNE_LIMIT_S,
	parameter int unsigned FLASH_CYCLES      = FLASH_CYC
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        key_shift,
	input  wire logic        key_up,
	input  wire logic        key_down,
	input  wire logic        run_contact,
	input  wire logic        supply_ok,
	input  wire logic        valve_feedback_input,
	input  wire logic [15:0] measured_value,
	input  wire logic        pv_underscale,
	input  wire logic        pv_overscale,
	input  wire logic        instrument_fail,
	input  wire logic        tune_done,
	input  wire logic [15:0] new_p,
	input  wire logic [15:0] new_i,
	input  wire logic [15:0] new_d,
	input  wire logic        ctl_on,
	output logic             auto_tuning,
	output logic             tune_lamp,
	output logic             tune_start,
	output logic             tune_abort,
	output logic             tuning_selector,
	output logic             run_active,
	output logic      [15:0] pid_p,
	output logic      [15:0] pid_i,
	output logic      [15:0] pid_d,
	output logic      [15:0] drive_value
);
	// ----------------------------------------------------------------
	// Parameter checks
	// ----------------------------------------------------------------
	if (SEC_CYCLES < 1 || FLASH_CYCLES < 1 || TUNE_LIMIT_SEC < 1 || TUNE_LIMIT_SEC > 65535) begin : g_bad
		$error("pid_autotune_sequencer timing parameters out of range");
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		tune_state_e st;
		logic [4:0]  ctrl;
		logic [15:0] lim_hi;
		logic [15:0] lim_lo;
		logic [15:0] err_hi;
		logic [15:0] err_lo;
		logic [15:0] target;
		logic [31:0] pv_adj;
		logic [15:0] area;
		logic [15:0] tune_on;
		logic [15:0] tune_off;
		logic [15:0] i_lim;
		logic [15:0] d_lim;
		logic [15:0] p;
		logic [15:0] i;
		logic [15:0] d;
		logic        screen;
		logic        run_pin;
		logic [2:0]  kprev;
		logic [31:0] presc;
		logic [15:0] secs;
		logic [31:0] flash_cnt;
		logic        lamp;
		cause_e      cause;
		logic        refused;
		logic        start;
		logic        abort;
		logic [15:0] drive;
		logic [31:0] rdata;
		logic        err;
	} seq_s;

	seq_s s;
	seq_s next_s;

	logic [5:0] pin_q;
	logic       shift_fire;
	logic       run_fire;
	logic       pwr_lost;
	logic       run_eff;
	logic       start_ok;
	logic       pv_ok;
	logic       cancel;
	cause_e     cancel_cause;
	logic       chg_target;
	logic       chg_pvadj;
	logic       chg_area;
	logic       apply_tune_out;
	logic       up_rise;
	logic       down_rise;
	logic       shift_rise;
	logic       tuning;
	logic       sec_tick;

	// ----------------------------------------------------------------
	// Pin inputs
	// ----------------------------------------------------------------
	pin_sync3 #(.W(6), .INIT(6'h18)) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.pin     ({valve_feedback_input, supply_ok, run_contact, key_down, key_up, key_shift}),
		.q       (pin_q)
	);

	hold_timer #(.CYCLES(SHIFT_HOLD_CYCLES)) u_shift_hold (
		.pclk    (pclk),
		.presetn (presetn),
		.level   (pin_q[0] && !s.screen),
		.fire    (shift_fire),
		.held    ()
	);

	hold_timer #(.CYCLES(PWR_FAIL_CYCLES)) u_pwr_fail (
		.pclk    (pclk),
		.presetn (presetn),
		.level   (!pin_q[4]),
		.fire    (),
		.held    (pwr_lost)
	);

	// The contact only wins after it has stayed changed for the whole settle time.
	hold_timer #(.CYCLES(RUN_SETTLE_CYCLES)) u_run_settle (
		.pclk    (pclk),
		.presetn (presetn),
		.level   (pin_q[3] != s.run_pin),
		.fire    (run_fire),
		.held    ()
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_s      = s;
		next_s.start = 1'b0;
		next_s.abort = 1'b0;
		next_s.kprev = pin_q[2:0];
		tuning      = (s.st == ST_TUNE);
		shift_rise  = pin_q[0] && !s.kprev[0];
		up_rise     = pin_q[1] && !s.kprev[1];
		down_rise   = pin_q[2] && !s.kprev[2];
		run_eff     = s.ctrl[CTRL_RUN] && s.run_pin;
		chg_target  = 1'b0;
		chg_pvadj   = 1'b0;
		chg_area    = 1'b0;

		if (run_fire) begin
			next_s.run_pin = pin_q[3];
		end
		if (shift_fire) begin
			next_s.screen = 1'b1;
		end else if (shift_rise && s.screen) begin
			next_s.screen = 1'b0;
		end

		if (psel && penable && pwrite) begin
			case (paddr)
				A_CTRL: begin
					next_s.ctrl = pwdata[4:0];
				end
				A_OUTLIM: begin
					next_s.lim_hi = pwdata[15:0];
					next_s.lim_lo = pwdata[31:16];
				end
				A_ERRPT: begin
					next_s.err_hi = pwdata[15:0];
					next_s.err_lo = pwdata[31:16];
				end
				A_TARGET: begin
					chg_target    = (pwdata[15:0] != s.target);
					next_s.target = pwdata[15:0];
				end
				A_PVADJ: begin
					chg_pvadj     = (pwdata != s.pv_adj);
					next_s.pv_adj = pwdata;
				end
				A_AREA: begin
					chg_area    = (pwdata[15:0] != s.area);
					next_s.area = pwdata[15:0];
				end
				A_TUNOUT: begin
					next_s.tune_on  = pwdata[15:0];
					next_s.tune_off = pwdata[31:16];
				end
				A_LIMIT: begin
					next_s.i_lim = pwdata[15:0];
					next_s.d_lim = pwdata[31:16];
				end
				// The working values are frozen during tuning so a cancel finds them intact.
				A_PID_P: begin
					if (!tuning) next_s.p = pwdata[15:0];
				end
				A_PID_I: begin
					if (!tuning) next_s.i = pwdata[15:0];
				end
				A_PID_D: begin
					if (!tuning) next_s.d = pwdata[15:0];
				end
				default: begin
				end
			endcase
		end

		pv_ok = !pv_underscale && !pv_overscale && measured_value <= s.err_hi
			&& measured_value >= s.err_lo;
		start_ok = run_eff && s.ctrl[CTRL_AUTO] && s.ctrl[CTRL_LOCAL] && s.ctrl[CTRL_PID]
			&& s.lim_hi >= OUT_HI_MIN && s.lim_lo <= OUT_LO_MAX && pv_ok;

		cancel       = 1'b1;
		cancel_cause = C_NONE;
		if (!run_eff) cancel_cause = C_STOP;
		else if (s.screen && down_rise) cancel_cause = C_SEL;
		else if (!s.ctrl[CTRL_AUTO]) cancel_cause = C_MANUAL;
		else if (!s.ctrl[CTRL_LOCAL]) cancel_cause = C_REMOTE;
		else if (chg_target) cancel_cause = C_TARGET;
		else if (chg_pvadj) cancel_cause = C_PVADJ;
		else if (chg_area) cancel_cause = C_AREA;
		else if (pv_underscale || pv_overscale || measured_value >= s.err_hi
			|| measured_value <= s.err_lo) cancel_cause = C_INPUT;
		else if (s.secs >= TUNE_LIMIT_SEC[15:0]) cancel_cause = C_TIMEOUT;
		else if (pwr_lost) cancel_cause = C_POWER;
		else if (instrument_fail) cancel_cause = C_FAIL;
		else cancel = 1'b0;

		sec_tick = (s.presc == SEC_CYCLES - 1);
		case (s.st)
			ST_IDLE: begin
				next_s.presc = '0;
				next_s.secs  = '0;
				// Idle has no time or temperature gate of its own.
				if (s.screen && up_rise) begin
					if (start_ok) begin
						next_s.st      = ST_TUNE;
						next_s.start   = 1'b1;
						next_s.refused = 1'b0;
						next_s.cause   = C_NONE;
					end else begin
						next_s.refused = 1'b1;
					end
				end
			end
			ST_TUNE: begin
				next_s.presc = sec_tick ? 32'h0 : s.presc + 32'h1;
				next_s.secs  = sec_tick ? s.secs + 16'h1 : s.secs;
				// A cancel in the same cycle as completion wins: the new values may be unsound.
				if (cancel) begin
					next_s.st    = ST_IDLE;
					next_s.abort = 1'b1;
					next_s.cause = cancel_cause;
				end else if (tune_done) begin
					next_s.st    = ST_IDLE;
					next_s.cause = C_DONE;
					next_s.p     = new_p;
					next_s.i     = (new_i > s.i_lim) ? s.i_lim : new_i;
					next_s.d     = (new_d > s.d_lim) ? s.d_lim : new_d;
				end
			end
			default: begin
				next_s.st = ST_IDLE;
			end
		endcase

		if (tuning) begin
			if (s.flash_cnt == FLASH_CYCLES - 1) begin
				next_s.flash_cnt = '0;
				next_s.lamp      = !s.lamp;
			end else begin
				next_s.flash_cnt = s.flash_cnt + 32'h1;
			end
		end else begin
			next_s.flash_cnt = '0;
			next_s.lamp      = 1'b0;
		end

		apply_tune_out = tuning && (!s.ctrl[CTRL_VALVE] || pin_q[5]);
		if (apply_tune_out) begin
			next_s.drive = ctl_on ? s.tune_on : s.tune_off;
		end else begin
			next_s.drive = ctl_on ? s.lim_hi : s.lim_lo;
		end

		if (psel && !penable) begin
			next_s.err = 1'b0;
			case (paddr)
				A_CTRL:   next_s.rdata = {27'h0, s.ctrl};
				A_OUTLIM: next_s.rdata = {s.lim_lo, s.lim_hi};
				A_ERRPT:  next_s.rdata = {s.err_lo, s.err_hi};
				A_MEAS:   next_s.rdata = {14'h0, pv_overscale, pv_underscale, measured_value};
				A_TARGET: next_s.rdata = {16'h0, s.target};
				A_PVADJ:  next_s.rdata = s.pv_adj;
				A_AREA:   next_s.rdata = {16'h0, s.area};
				A_TUNOUT: next_s.rdata = {s.tune_off, s.tune_on};
				A_LIMIT:  next_s.rdata = {s.d_lim, s.i_lim};
				A_PID_P:  next_s.rdata = {16'h0, s.p};
				A_PID_I:  next_s.rdata = {16'h0, s.i};
				A_PID_D:  next_s.rdata = {16'h0, s.d};
				A_STATUS: next_s.rdata = {22'h0, pwr_lost, pin_q[5], s.cause, s.refused,
					s.screen, run_eff, tuning};
				default: begin
					next_s.rdata = '0;
					next_s.err   = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s          <= '0;
			s.st       <= ST_IDLE;
			s.ctrl     <= CTRL_RST;
			s.lim_hi   <= LIM_HI_RST;
			s.lim_lo   <= LIM_LO_RST;
			s.err_hi   <= ERR_HI_RST;
			s.err_lo   <= ERR_LO_RST;
			s.i_lim    <= LIMIT_RST;
			s.d_lim    <= LIMIT_RST;
			s.p        <= PID_P_RST;
			s.i        <= PID_I_RST;
			s.d        <= PID_D_RST;
			s.cause    <= C_NONE;
			s.run_pin  <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign pready          = 1'b1;
	assign prdata          = s.rdata;
	assign pslverr         = s.err;
	assign auto_tuning     = (s.st == ST_TUNE);
	assign tune_lamp       = s.lamp;
	assign tune_start      = s.start;
	assign tune_abort      = s.abort;
	assign tuning_selector = s.screen;
	assign run_active      = s.ctrl[CTRL_RUN] && s.run_pin;
	assign pid_p           = s.p;
	assign pid_i           = s.i;
	assign pid_d           = s.d;
	assign drive_value     = s.drive;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	cause_e cancel_cause_q;
	cause_e cause;

	sequence s_tuning_cancel;
		auto_tuning && cancel;
	endsequence

	sequence s_left_by_abort;
		!auto_tuning && tune_abort && cause == cancel_cause_q;
	endsequence

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cancel_cause_q <= C_NONE;
		end else begin
			cancel_cause_q <= cancel_cause;
		end
	end
	assign cause = s.cause;

	chk_start_mode: assert property ($rose(auto_tuning) |-> $past(run_eff && s.ctrl[CTRL_AUTO]
		&& s.ctrl[CTRL_LOCAL] && s.ctrl[CTRL_PID])) else $error("tuning began outside allowed mode");
	chk_start_limits: assert property ($rose(auto_tuning) |-> $past(s.lim_hi >= OUT_HI_MIN
		&& s.lim_lo <= OUT_LO_MAX)) else $error("tuning began with bad output limits");
	chk_start_input: assert property ($rose(auto_tuning) |-> $past(pv_ok))
		else $error("tuning began with invalid measured value");
	chk_start_pulse: assert property ($rose(auto_tuning) |-> tune_start && tuning_selector)
		else $error("tuning start without pulse or selector");
	chk_lamp_idle: assert property (!auto_tuning |-> ##1 !tune_lamp)
		else $error("lamp lit while not tuning");
	chk_done_load: assert property (auto_tuning && tune_done && !cancel |=> !auto_tuning
		&& pid_p == $past(new_p) && !tune_abort) else $error("completion did not load values");
	chk_cancel_exit: assert property (s_tuning_cancel |=> s_left_by_abort)
		else $error("cancel did not leave tuning");
	chk_pid_frozen: assert property (auto_tuning && !tune_done |=> $stable(pid_p) && $stable(pid_i)
		&& $stable(pid_d)) else $error("values moved during tuning");
	chk_stop_cancel: assert property (auto_tuning && !run_active |=> !auto_tuning)
		else $error("stop did not cancel tuning");
	chk_time_limit: assert property (auto_tuning |-> s.secs <= TUNE_LIMIT_SEC[15:0])
		else $error("tuning ran past its time limit");
	chk_limiter: assert property (auto_tuning && tune_done && !cancel |=> pid_i <= $past(s.i_lim)
		&& pid_d <= $past(s.d_lim)) else $error("limiter not applied");
	chk_drive_clamp: assert property (apply_tune_out |=> drive_value == ($past(ctl_on)
		? $past(s.tune_on) : $past(s.tune_off))) else $error("tuning output not applied");
	chk_drive_idle: assert property (!auto_tuning |=> drive_value == ($past(ctl_on)
		? $past(s.lim_hi) : $past(s.lim_lo))) else $error("tuning output used outside tuning");
endmodule

// ===== test/panel_model.sv
`timescale 1ns/1ps
module panel_model (
	input  wire logic        pclk,
	output logic             key_shift,
	output logic             key_up,
	output logic             key_down,
	output logic      [15:0] measured_value,
	output logic             pv_underscale,
	output logic             pv_overscale,
	output logic             tune_done,
	output logic      [15:0] new_p,
	output logic      [15:0] new_i,
	output logic      [15:0] new_d
);
	// ----------------------------------------------------------------
	// Keys and process input
	// ----------------------------------------------------------------
	logic [2:0] keys;

	assign {key_shift, key_up, key_down} = keys;

	initial begin
		keys = 3'h0;
		measured_value = 16'h0100;
		{pv_underscale, pv_overscale, tune_done} = 3'h0;
		{new_p, new_i, new_d} = 48'h0;
	end

	// Key index: 0 down, 1 up, 2 shift.
	task automatic press(input int k, input int n);
		@(posedge pclk);
		keys <= 3'(1 << k);
		repeat (n) @(posedge pclk);
		keys <= 3'h0;
	endtask

	task automatic set_flags(input logic u, input logic o);
		@(posedge pclk);
		{pv_underscale, pv_overscale} <= {u, o};
	endtask

	task automatic finish(input logic [15:0] p, input logic [15:0] i, input logic [15:0] d);
		@(posedge pclk);
		tune_done <= 1'b1;
		{new_p, new_i, new_d} <= {p, i, d};
		@(posedge pclk);
		tune_done <= 1'b0;
		// Values are only valid with the pulse, so they are spoiled afterwards.
		{new_p, new_i, new_d} <= ~{p, i, d};
	endtask
endmodule

// ===== test/testbench.sv
`timescale 1ns/1ps
module testbench;
	import pid_autotune_pkg::*;
	// ----------------------------------------------------------------
	// Signals, clock and instances
	// ----------------------------------------------------------------
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, r;
	logic        key_shift, key_up, key_down, run_contact, supply_ok, valve_feedback_input;
	logic [15:0] measured_value, new_p, new_i, new_d, pid_p, pid_i, pid_d, drive_value;
	logic        pv_underscale, pv_overscale, instrument_fail, tune_done, ctl_on;
	logic        auto_tuning, tune_lamp, tune_start, tune_abort, tuning_selector, run_active, l;
	int          miscompares = 0;
	int          tests_run = 0;
	int          starts = 0;
	int          aborts = 0;

	// Pulses last one cycle, so they are counted mid-cycle where they are settled.
	always @(negedge pclk) begin
		if (tune_start === 1'b1) starts++;
		if (tune_abort === 1'b1) aborts++;
	end

	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	pid_autotune_sequencer #(.SHIFT_HOLD_CYCLES(8), .PWR_FAIL_CYCLES(5), .RUN_SETTLE_CYCLES(6),
		.SEC_CYCLES(50), .TUNE_LIMIT_SEC(3), .FLASH_CYCLES(2)) i_pid_autotune_sequencer (
		.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
		.key_shift, .key_up, .key_down, .run_contact, .supply_ok, .valve_feedback_input,
		.measured_value, .pv_underscale, .pv_overscale, .instrument_fail, .tune_done,
		.new_p, .new_i, .new_d, .ctl_on, .auto_tuning, .tune_lamp, .tune_start, .tune_abort,
		.tuning_selector, .run_active, .pid_p, .pid_i, .pid_d, .drive_value);

	panel_model i_panel_model (.pclk, .key_shift, .key_up, .key_down, .measured_value,
		.pv_underscale, .pv_overscale, .tune_done, .new_p, .new_i, .new_d);

	task automatic report_and_stop();
		$display("Checks %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk1(input string n, input logic e, input logic g);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("Error %s expected %b seen %b", n, e, g);
		end
	endtask

	task automatic chk32(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		{psel, penable} <= 2'b00;
	endtask

	task automatic wt(input logic v, input int n);
		repeat (n) begin
			@(posedge pclk);
			#1;
			if (auto_tuning === v) break;
		end
	endtask

	task automatic go();
		i_panel_model.press(1, 6);
		wt(1'b1, 30);
	endtask

	initial begin
		repeat (20000) @(posedge pclk);
		miscompares++;
		report_and_stop();
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{run_contact, supply_ok, valve_feedback_input, instrument_fail, ctl_on} = 5'b11101;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, A_CTRL, 0);
		chk32("ctrl", 32'h0F, r);
		apb(0, A_LIMIT, 0);
		chk32("limit", 32'hFFFFFFFF, r);
		apb(0, 8'h40, 0);
		chk1("unmapped", 1'b1, pslverr);
		chk1("pready", 1'b1, pready);
		$display("Test reset done");
		i_panel_model.press(2, 16);
		repeat (8) @(posedge pclk);
		chk1("selector", 1'b1, tuning_selector);
		apb(1, A_OUTLIM, 0);
		go();
		chk1("refused lim", 1'b0, auto_tuning);
		apb(0, A_STATUS, 0);
		chk1("refused bit", 1'b1, r[3]);
		apb(1, A_OUTLIM, 32'h03E8);
		apb(1, A_CTRL, 32'h07);
		go();
		chk1("refused mode", 1'b0, auto_tuning);
		apb(1, A_CTRL, 32'h0F);
		i_panel_model.set_flags(1'b0, 1'b1);
		go();
		chk1("refused pv", 1'b0, auto_tuning);
		i_panel_model.set_flags(1'b0, 1'b0);
		$display("Test start conditions done");
		apb(1, A_TUNOUT, 32'h0045_0123);
		apb(1, A_LIMIT, 32'h0005_0000);
		go();
		chk1("start", 1'b1, auto_tuning);
		l = tune_lamp;
		repeat (2) @(posedge pclk);
		#1 chk1("lamp", ~l, tune_lamp);
		chk32("starts", 1, starts);
		chk32("drive on", 32'h0123, 32'(drive_value));
		ctl_on <= 1'b0;
		repeat (2) @(posedge pclk);
		#1 chk32("drive off", 32'h0045, 32'(drive_value));
		apb(1, A_CTRL, 32'h1F);
		valve_feedback_input <= 1'b0;
		repeat (6) @(posedge pclk);
		#1 chk32("valve no fb", 32'h0000, 32'(drive_value));
		{ctl_on, valve_feedback_input} <= 2'b11;
		apb(1, A_CTRL, 32'h0F);
		i_panel_model.finish(16'h0011, 16'h0022, 16'h0033);
		wt(1'b0, 5);
		chk1("done", 1'b0, auto_tuning);
		@(posedge pclk);
		#1 chk1("lamp off", 1'b0, tune_lamp);
		chk32("pid pi", 32'h0011_0000, {pid_p, pid_i});
		chk32("pid d", 32'h0005, 32'(pid_d));
		chk32("drive hi", 32'h03E8, 32'(drive_value));
		chk32("aborts", 0, aborts);
		$display("Test tuning done");
		for (int c = 2; c <= 12; c++) begin
			go();
			case (c)
				2: apb(1, A_CTRL, 32'h0E);
				3: i_panel_model.press(0, 6);
				4: apb(1, A_CTRL, 32'h0D);
				5: apb(1, A_CTRL, 32'h0B);
				6: apb(1, A_TARGET, 32'h0055);
				7: apb(1, A_PVADJ, 32'h0001);
				8: apb(1, A_AREA, 32'h0001);
				9: i_panel_model.set_flags(1'b1, 1'b0);
				11: supply_ok <= 1'b0;
				12: instrument_fail <= 1'b1;
				default: ;
			endcase
			wt(1'b0, 200);
			chk1("cancel", 1'b0, auto_tuning);
			chk32("kept pid", 32'h0011, 32'(pid_p));
			apb(0, A_STATUS, 0);
			chk32("cause", c, 32'(r[7:4]));
			chk32("aborts", c - 1, aborts);
			{supply_ok, instrument_fail} <= 2'b10;
			apb(1, A_CTRL, 32'h0F);
			i_panel_model.set_flags(1'b0, 1'b0);
			repeat (6) @(posedge pclk);
		end
		$display("Test cancel done");
		run_contact <= 1'b0;
		repeat (10) @(posedge pclk);
		#1 chk1("run held", 1'b1, run_active);
		@(posedge pclk);
		#1 chk1("run off", 1'b0, run_active);
		$display("Test run contact done");
		report_and_stop();
	end
endmodule
